// File: sync_serial_pkg.sv
package sync_serial_pkg;

    // ==========================================================
    // Register map (word aligned byte addresses)
    // ==========================================================
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_DATA_LOW  = 8'h08;
    localparam logic [7:0] ADDR_DATA_HIGH = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_REQ   = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h14;
    localparam logic [7:0] ADDR_PIN_CFG   = 8'h18;

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam int          STAT_RSVD     = 7;
    localparam int          STAT_SOL      = 6;
    localparam int          STAT_OVERRUN_ERROR_FLAG     = 5;
    localparam int          STAT_STF      = 0;
    localparam int          CLK_EXT_BIT   = 3;
    localparam logic [7:0]  STATUS_FIXED  = 8'h80;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [7:0]  PIN_RESET     = 8'h00;
    localparam logic [4:0]  LAST_BIT_8    = 5'h07;
    localparam logic [4:0]  LAST_BIT_16   = 5'h0f;

    // ==========================================================
    // Types
    // ==========================================================
    typedef struct packed {
        logic       mode_select_upper;
        logic       mode_select_lower;
        logic [1:0] unused;
        logic [3:0] clk_sel;
    } ctrl_t;

    typedef struct packed {
        logic [3:0] unused;
        logic       open_drain_select;
        logic       sck_func;
        logic       si_func;
        logic       so_func;
    } pin_cfg_t;

    typedef enum logic { ST_IDLE, ST_RUN } state_t;

    // Half serial clock period in pclk cycles for taps /1024 to /2
    function automatic logic [9:0] half_period(input logic [2:0] sel);
        case (sel)
            3'h0:    half_period = 10'h200;
            3'h1:    half_period = 10'h080;
            3'h2:    half_period = 10'h020;
            3'h3:    half_period = 10'h010;
            3'h4:    half_period = 10'h008;
            3'h5:    half_period = 10'h004;
            3'h6:    half_period = 10'h002;
            default: half_period = 10'h001;
        endcase
    endfunction : half_period

endpackage : sync_serial_pkg

// File: clocked_serial_shift_port.sv
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
// Function
// - Data-out pin may be open drain, else drives both levels.
// - Upper mode bit must be 0; lower bit picks 16 or 8 bits.
// - Four-bit clock select picks internal prescaler tap or external clock.
// - Any control register write reinitialises transfer state.
// - 8-bit uses low data register; 16-bit adds high as upper byte.
// - Setting start flag begins shifting transmit data out.
// - Completion sets the transfer-done request flag.
// - Internal clock follows data; no pulses after completion until restart.
// - Data-out keeps the last shifted bit after completion.
// - External clock mode shifts only on partner-supplied clock edges.
// - Extra external pulses after transmit shift nothing and set overrun.
// - Idle writes of output-level bit change data-out at once.
// - Start flag in receive use begins sampling data-in.
// - Extra pulses after receive capture nothing and set overrun.
// - Simultaneous mode shifts both ways; done after both complete.
// - Done request interrupts only when the enable bit is set.
// - LSB first; output changes on falling edge, input sampled rising.
// - Start flag reads 1 while busy, cleared on completion.
// - Overrun clears only by writing 0 after reading 1.
// - Output-level setting lasts only until the next transmission.
module clocked_serial_shift_port (
    input  wire logic        pclk,             // System clock
    input  wire logic        presetn,          // Async reset, low
    input  wire logic        psel,             // APB select
    input  wire logic        penable,          // APB enable
    input  wire logic        pwrite,           // APB direction
    input  wire logic [7:0]  paddr,            // APB byte address
    input  wire logic [31:0] pwdata,           // APB write data
    output logic      [31:0] prdata,           // APB read data
    output logic             pready,           // APB ready
    output logic             pslverr,          // APB unmapped access
    input  wire logic        serial_data_in,   // Data-in pin
    output logic             serial_data_out,  // Data-out pin level
    output logic             serial_data_oe,   // Data-out drive enable
    input  wire logic        serial_clock_in,  // Clock pin input
    output logic             serial_clock_out, // Clock pin level
    output logic             serial_clock_oe,  // Clock pin drive enable
    output logic             transfer_irq      // Gated done request
);

    // ==========================================================
    // State
    // ==========================================================
    sync_serial_pkg::ctrl_t    ctrl_q, ctrl_d;
    sync_serial_pkg::pin_cfg_t pin_q, pin_d;
    sync_serial_pkg::state_t   state_q, state_d;
    logic [7:0]  low_q, low_d, high_q, high_d;
    logic [4:0]  bits_q, bits_d;
    logic [9:0]  div_q, div_d;
    logic        sclk_q, sclk_d, so_q, so_d, stf_q, stf_d;
    logic        overrun_error_flag_q, overrun_error_flag_d, overrun_error_flag_rd_q, overrun_error_flag_rd_d;
    logic        done_q, done_d, done_req_q, done_req_d;
    logic        irq_en_q, irq_en_d, so_oe_q, sck_oe_q, irq_q;
    logic        sck_s1_q, sck_s2_q, sck_s3_q;
    logic        rdy_q, rdy_d, err_d;
    logic [31:0] rdata_q, rdata_d;
    logic        acc, wr_en, rd_en, ext, tick, rise_ev, fall_ev;
    logic [4:0]  last_bit;
    logic [7:0]  status_rd;

    // ==========================================================
    // APB decode
    // ==========================================================
    // No access gets a wait state; rdata is registered during the setup cycle
    assign acc       = psel & penable & rdy_q;
    assign wr_en     = acc & pwrite;
    assign rd_en     = acc & ~pwrite;
    assign status_rd = sync_serial_pkg::STATUS_FIXED
                     | {1'b0, so_q, overrun_error_flag_q, 4'h0, stf_q};

    // Bus answer and read mux
    always_comb begin
        rdy_d   = psel & ~penable & ~rdy_q;
        err_d   = 1'b0;
        rdata_d = 32'h0000_0000;
        if (rdy_d) begin
            case (paddr)
                sync_serial_pkg::ADDR_CTRL:      rdata_d[7:0] = ctrl_q;
                sync_serial_pkg::ADDR_STATUS:    rdata_d[7:0] = status_rd;
                sync_serial_pkg::ADDR_DATA_LOW:  rdata_d[7:0] = low_q;
                sync_serial_pkg::ADDR_DATA_HIGH: rdata_d[7:0] = high_q;
                sync_serial_pkg::ADDR_IRQ_REQ:   rdata_d[0]   = done_req_q;
                sync_serial_pkg::ADDR_IRQ_EN:    rdata_d[0]   = irq_en_q;
                sync_serial_pkg::ADDR_PIN_CFG:   rdata_d[7:0] = pin_q;
                default:                         err_d        = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_q   <= 1'b0;
            pslverr <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            rdy_q   <= rdy_d;
            pslverr <= err_d;
            rdata_q <= rdata_d;
        end
    end

    assign pready = rdy_q;
    assign prdata = rdata_q;

    // ==========================================================
    // External clock synchroniser
    // ==========================================================
    // Third stage only feeds the edge detector, never the first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_s1_q <= 1'b1;
            sck_s2_q <= 1'b1;
            sck_s3_q <= 1'b1;
        end else begin
            sck_s1_q <= serial_clock_in;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
        end
    end

    // ==========================================================
    // Shift engine and registers
    // ==========================================================
    assign ext      = ctrl_q.clk_sel[sync_serial_pkg::CLK_EXT_BIT];
    assign last_bit = ctrl_q.mode_select_lower ? sync_serial_pkg::LAST_BIT_8
                                               : sync_serial_pkg::LAST_BIT_16;
    assign tick     = (state_q == sync_serial_pkg::ST_RUN) & ~ext
                    & (div_q == sync_serial_pkg::half_period(
                           ctrl_q.clk_sel[2:0]) - 10'h001);
    // Edges: internal divider or synchronised external pin
    assign fall_ev  = (state_q == sync_serial_pkg::ST_RUN)
                    & (ext ? (~sck_s2_q & sck_s3_q) : (tick & sclk_q));
    assign rise_ev  = (state_q == sync_serial_pkg::ST_RUN)
                    & (ext ? (sck_s2_q & ~sck_s3_q) : (tick & ~sclk_q));

    // Next state: bus writes first, hardware sets after so sets win; a control write comes last and wins over both for the engine fields it clears
    always_comb begin
        ctrl_d     = ctrl_q;
        pin_d      = pin_q;
        state_d    = state_q;
        low_d      = low_q;
        high_d     = high_q;
        bits_d     = bits_q;
        div_d      = div_q;
        sclk_d     = sclk_q;
        so_d       = so_q;
        stf_d      = stf_q;
        overrun_error_flag_d     = overrun_error_flag_q;
        overrun_error_flag_rd_d  = overrun_error_flag_rd_q;
        done_d     = done_q;
        done_req_d = done_req_q;
        irq_en_d   = irq_en_q;
        if (rd_en && paddr == sync_serial_pkg::ADDR_STATUS && overrun_error_flag_q)
            overrun_error_flag_rd_d = 1'b1;
        if (wr_en) begin
            case (paddr)
                sync_serial_pkg::ADDR_STATUS: begin
                    if (state_q == sync_serial_pkg::ST_IDLE)
                        so_d = pwdata[sync_serial_pkg::STAT_SOL];
                    if (!pwdata[sync_serial_pkg::STAT_OVERRUN_ERROR_FLAG] && overrun_error_flag_rd_q) begin
                        overrun_error_flag_d    = 1'b0;
                        overrun_error_flag_rd_d = 1'b0;
                    end
                    // Start refused while busy or in a non-sync mode
                    if (pwdata[sync_serial_pkg::STAT_STF]
                        && state_q == sync_serial_pkg::ST_IDLE
                        && !ctrl_q.mode_select_upper) begin
                        state_d = sync_serial_pkg::ST_RUN;
                        stf_d   = 1'b1;
                        bits_d  = 5'h00;
                        div_d   = 10'h000;
                        sclk_d  = 1'b1;
                        done_d  = 1'b0;
                    end
                end
                sync_serial_pkg::ADDR_DATA_LOW:  low_d  = pwdata[7:0];
                sync_serial_pkg::ADDR_DATA_HIGH: high_d = pwdata[7:0];
                sync_serial_pkg::ADDR_IRQ_REQ:
                    if (!pwdata[0])
                        done_req_d = 1'b0;
                sync_serial_pkg::ADDR_IRQ_EN:    irq_en_d = pwdata[0];
                sync_serial_pkg::ADDR_PIN_CFG:   pin_d    = pwdata[7:0];
                default: ;
            endcase
        end
        // Internal divider only runs during a transfer
        if (state_q == sync_serial_pkg::ST_RUN && !ext) begin
            div_d = tick ? 10'h000 : div_q + 10'h001;
            if (tick)
                sclk_d = ~sclk_q;
        end
        // Output bit changes on falling edge, replacing any level set
        if (fall_ev)
            so_d = low_q[0];
        if (rise_ev) begin
            if (ctrl_q.mode_select_lower)
                low_d = {serial_data_in, low_q[7:1]};
            else
                {high_d, low_d} = {serial_data_in, high_q, low_q[7:1]};
            bits_d = bits_q + 5'h01;
            if (bits_q == last_bit) begin
                state_d    = sync_serial_pkg::ST_IDLE;
                stf_d      = 1'b0;
                done_d     = 1'b1;
                done_req_d = 1'b1;
            end
        end
        // Extra external pulses only raise overrun, no data moves
        if (state_q == sync_serial_pkg::ST_IDLE && ext && done_q
            && sck_s2_q && !sck_s3_q)
            overrun_error_flag_d = 1'b1;
        // Control write stops the engine and returns it to a clean idle state
        if (wr_en && paddr == sync_serial_pkg::ADDR_CTRL) begin
            ctrl_d  = pwdata[7:0];
            state_d = sync_serial_pkg::ST_IDLE;
            bits_d  = 5'h00;
            div_d   = 10'h000;
            sclk_d  = 1'b1;
            stf_d   = 1'b0;
            done_d  = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= sync_serial_pkg::CTRL_RESET;
            pin_q      <= sync_serial_pkg::PIN_RESET;
            state_q    <= sync_serial_pkg::ST_IDLE;
            low_q      <= 8'h00;
            high_q     <= 8'h00;
            bits_q     <= 5'h00;
            div_q      <= 10'h000;
            sclk_q     <= 1'b1;
            so_q       <= 1'b0;
            stf_q      <= 1'b0;
            overrun_error_flag_q     <= 1'b0;
            overrun_error_flag_rd_q  <= 1'b0;
            done_q     <= 1'b0;
            done_req_q <= 1'b0;
            irq_en_q   <= 1'b0;
        end else begin
            ctrl_q     <= ctrl_d;
            pin_q      <= pin_d;
            state_q    <= state_d;
            low_q      <= low_d;
            high_q     <= high_d;
            bits_q     <= bits_d;
            div_q      <= div_d;
            sclk_q     <= sclk_d;
            so_q       <= so_d;
            stf_q      <= stf_d;
            overrun_error_flag_q     <= overrun_error_flag_d;
            overrun_error_flag_rd_q  <= overrun_error_flag_rd_d;
            done_q     <= done_d;
            done_req_q <= done_req_d;
            irq_en_q   <= irq_en_d;
        end
    end

    // ==========================================================
    // Pin drivers and interrupt
    // ==========================================================
    // Open drain only ever pulls low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            so_oe_q  <= 1'b0;
            sck_oe_q <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            so_oe_q  <= pin_d.so_func
                      & (~pin_d.open_drain_select | ~so_d);
            sck_oe_q <= pin_d.sck_func
                      & ~ctrl_d.clk_sel[sync_serial_pkg::CLK_EXT_BIT];
            irq_q    <= done_req_q & irq_en_q;
        end
    end

    assign serial_data_out  = so_q;
    assign serial_data_oe   = so_oe_q;
    assign serial_clock_out = sclk_q;
    assign serial_clock_oe  = sck_oe_q;
    assign transfer_irq     = irq_q;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence last_rise_s;
        rise_ev && bits_q == last_bit
        && !(wr_en && paddr == sync_serial_pkg::ADDR_CTRL);
    endsequence

    done_on_last_a: assert property (
        last_rise_s |=> !stf_q && done_req_q)
        else $error("transfer did not complete on last bit");
    ctrl_reinit_a: assert property (
        wr_en && paddr == sync_serial_pkg::ADDR_CTRL
        |=> state_q == sync_serial_pkg::ST_IDLE && bits_q == 5'h00)
        else $error("control write left engine running");
    start_runs_a: assert property (
        wr_en && paddr == sync_serial_pkg::ADDR_STATUS
        && pwdata[sync_serial_pkg::STAT_STF]
        && state_q == sync_serial_pkg::ST_IDLE && !ctrl_q.mode_select_upper
        |=> stf_q && state_q == sync_serial_pkg::ST_RUN)
        else $error("start flag did not start a transfer");
    overrun_set_a: assert property (
        state_q == sync_serial_pkg::ST_IDLE
        && ext && done_q && sck_s2_q && !sck_s3_q |=> overrun_error_flag_q)
        else $error("extra clock did not set overrun");
    sol_level_a: assert property (
        wr_en && paddr == sync_serial_pkg::ADDR_STATUS
        && state_q == sync_serial_pkg::ST_IDLE
        |=> so_q == $past(pwdata[sync_serial_pkg::STAT_SOL]))
        else $error("idle level write not on pin");
    lsb_out_a: assert property (fall_ev |=> so_q == $past(low_q[0]))
        else $error("wrong bit on data out");
    idle_quiet_a: assert property (
        state_q == sync_serial_pkg::ST_IDLE
        && $past(state_q) == sync_serial_pkg::ST_IDLE
        |-> $stable(sclk_q))
        else $error("clock moved while idle");
    irq_gate_a: assert property (transfer_irq |-> $past(irq_en_q))
        else $error("interrupt without enable");
    overrun_hold_a: assert property (overrun_error_flag_q && !overrun_error_flag_rd_q |=> overrun_error_flag_q)
        else $error("overrun cleared without prior read");
    count_bits_a: assert property (
        state_q == sync_serial_pkg::ST_RUN |-> bits_q <= last_bit)
        else $error("bit counter past word length");

endmodule : clocked_serial_shift_port

// File: serial_partner.sv
`timescale 1ns/1ns
// ==========================================================
// Far-side clocked serial device
// ==========================================================
module serial_partner (
    input  wire logic pclk,     // System clock
    input  wire logic sclk_pin, // Resolved clock pin
    input  wire logic so_pin,   // Resolved data-out pin
    output wire logic si_pin,   // Data-in pin drive
    output logic      ext_clk   // Clock drive, idles high
);
    logic [15:0] tx_word = 16'h0000;
    logic [15:0] rx_word = 16'h0000;
    logic        si_bit  = 1'b0;
    logic        tog     = 1'b0;
    logic        spent   = 1'b1;
    int          nbits   = 0;
    int          tx_idx  = 0;
    int          rx_cnt  = 0;

    initial ext_clk = 1'b1;
    // Churn only after a fall past the last bit; the port samples its
    // last bit a few cycles after the pin rises, so hold it till then
    assign si_pin = spent ? tog : si_bit;
    always @(posedge pclk) tog <= ~tog;
    // Next bit on each falling edge, LSB first
    always @(negedge sclk_pin) begin
        if (tx_idx < nbits) begin
            si_bit <= tx_word[tx_idx];
            tx_idx <= tx_idx + 1;
        end else begin
            spent <= 1'b1;
        end
    end
    // Capture on each rising edge, LSB first
    always @(posedge sclk_pin) begin
        if (rx_cnt < nbits) begin
            rx_word[rx_cnt] <= so_pin;
            rx_cnt <= rx_cnt + 1;
        end
    end
    // Load one word to send, clear the capture
    task automatic arm(input logic [15:0] word, input int n);
        tx_word = word;
        nbits = n;
        tx_idx = 0;
        rx_cnt = 0;
        rx_word = 16'h0000;
        spent = 1'b0;
    endtask : arm
    // Caller only clocks after the start write
    task automatic pulses(input int n, input int h);
        repeat (n) begin
            repeat (h) @(posedge pclk);
            ext_clk <= 1'b0;
            repeat (h) @(posedge pclk);
            ext_clk <= 1'b1;
        end
    endtask : pulses
endmodule : serial_partner

// File: testbench.sv
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench for the serial shift port
// ==========================================================
module testbench;
    logic        pclk      = 1'b0;
    logic        presetn   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0;
    logic [31:0] prdata, rv;
    logic        pready, pslverr, slverr, so, so_oe, sck, sck_oe;
    logic        transfer_irq, ext_clk, sclk_prev;
    wire         si;
    int          fail_count = 0;
    int          tests_run  = 0;
    int          cyc = 0;
    int          falls = 0;
    int          last_fall = 0;
    int          gap = 0;
    int          mark;
    int          half_tab [8] = '{512, 128, 32, 16, 8, 4, 2, 1};
    wire         sclk_pin = sck_oe ? sck : ext_clk;
    wire         so_pin   = so_oe ? so : 1'b1; // Pull-up for open drain

    clocked_serial_shift_port uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_data_in(si), .serial_data_out(so),
        .serial_data_oe(so_oe), .serial_clock_in(sclk_pin),
        .serial_clock_out(sck), .serial_clock_oe(sck_oe),
        .transfer_irq(transfer_irq));
    serial_partner link (.pclk(pclk), .sclk_pin(sclk_pin), .so_pin(so_pin),
        .si_pin(si), .ext_clk(ext_clk));

    always #5 pclk = ~pclk;
    // Falling edges sampled on pclk, so spacing never races
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        sclk_prev <= sclk_pin;
        if (sclk_prev === 1'b1 && sclk_pin === 1'b0) begin
            gap <= cyc - last_fall;
            last_fall <= cyc;
            falls <= falls + 1;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; holds the request until pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rv = prdata;
        slverr = pslverr;
        if (n >= 50) fail_count++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    // Polls the request flag, never the status register
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            apb(1'b0, sync_serial_pkg::ADDR_IRQ_REQ, 8'h00);
            n++;
        end while (rv[0] !== 1'b1 && n < 5000);
        if (n >= 5000) fail_count++;
    endtask : wait_done

    // Level opposite to bit 0 proves the first bit overrides it
    task automatic start(input logic [7:0] c, input logic [15:0] d,
                         input logic [15:0] p, input int n);
        apb(1'b1, sync_serial_pkg::ADDR_IRQ_REQ, 8'h00);
        apb(1'b1, sync_serial_pkg::ADDR_CTRL, c);
        apb(1'b1, sync_serial_pkg::ADDR_DATA_LOW, d[7:0]);
        apb(1'b1, sync_serial_pkg::ADDR_DATA_HIGH, d[15:8]);
        link.arm(p, n);
        falls = 0;
        apb(1'b1, sync_serial_pkg::ADDR_STATUS, {1'b0, ~d[0], 6'h01});
    endtask : start

    task automatic t_reset();
        chk(32'(sck), 32'h1);
        apb(1'b0, sync_serial_pkg::ADDR_STATUS, 8'h00);
        chk(rv, 32'h80);
        apb(1'b0, 8'h1c, 8'h00);
        chk({rv[30:0], slverr}, 32'h1);
    endtask : t_reset

    task automatic t_level();
        apb(1'b1, sync_serial_pkg::ADDR_PIN_CFG, 8'h07);
        apb(1'b1, sync_serial_pkg::ADDR_STATUS, 8'h00);
        repeat (3) @(negedge pclk);
        chk(32'(so_pin), 32'h0);
        apb(1'b1, sync_serial_pkg::ADDR_STATUS, 8'h40);
        repeat (3) @(negedge pclk);
        chk(32'(so_pin), 32'h1);
        apb(1'b1, sync_serial_pkg::ADDR_PIN_CFG, 8'h09);
        repeat (3) @(negedge pclk);
        chk(32'(so_oe), 32'h0);
        apb(1'b1, sync_serial_pkg::ADDR_STATUS, 8'h00);
        repeat (3) @(negedge pclk);
        chk(32'({so_oe, so}), 32'h2);
        apb(1'b1, sync_serial_pkg::ADDR_PIN_CFG, 8'h07);
        apb(1'b1, sync_serial_pkg::ADDR_CTRL, 8'h86);
        apb(1'b1, sync_serial_pkg::ADDR_STATUS, 8'h01);
        apb(1'b0, sync_serial_pkg::ADDR_STATUS, 8'h00);
        chk(rv & 32'h1, 32'h0);
    endtask : t_level

    // Every internal tap, 8 bits, both directions at once
    task automatic t_taps();
        logic [7:0] d;
        apb(1'b1, sync_serial_pkg::ADDR_IRQ_EN, 8'h01);
        for (int s = 0; s < 8; s++) begin
            d = 8'ha5 ^ 8'(s);
            start(8'h40 | 8'(s), {8'h00, d}, {8'h00, 8'h3c + 8'(s)}, 8);
            wait_done();
            apb(1'b0, sync_serial_pkg::ADDR_DATA_LOW, 8'h00);
            chk(rv, 32'h3c + 32'(s));
            chk(32'(link.rx_word[7:0]), 32'(d));
            chk(32'(gap), 32'(2 * half_tab[s]));
            apb(1'b0, sync_serial_pkg::ADDR_STATUS, 8'h00);
            chk(rv, {24'h0, 1'b1, d[7], 6'h00});
            chk(32'(falls), 32'h8);
            chk(32'(transfer_irq), 32'h1);
        end
    endtask : t_taps

    task automatic t_wide();
        apb(1'b1, sync_serial_pkg::ADDR_IRQ_EN, 8'h00);
        start(8'h06, 16'h1234, 16'hbeef, 16);
        wait_done();
        apb(1'b0, sync_serial_pkg::ADDR_DATA_LOW, 8'h00);
        chk(rv, 32'hef);
        apb(1'b0, sync_serial_pkg::ADDR_DATA_HIGH, 8'h00);
        chk(rv, 32'hbe);
        chk(32'(link.rx_word), 32'h1234);
        chk(32'(falls), 32'h10);
        chk(32'(transfer_irq), 32'h0);
    endtask : t_wide

    // External clock, then surplus pulses for overrun
    task automatic t_ext();
        start(8'h48, 16'h0096, 16'h005a, 8);
        link.pulses(8, 8);
        wait_done();
        chk(32'(link.rx_word[7:0]), 32'h96);
        link.pulses(3, 8);
        repeat (10) @(posedge pclk);
        chk(32'(so_pin), 32'h1);
        apb(1'b0, sync_serial_pkg::ADDR_DATA_LOW, 8'h00);
        chk(rv, 32'h5a);
        apb(1'b0, sync_serial_pkg::ADDR_STATUS, 8'h00);
        chk(rv, 32'he0);
        apb(1'b1, sync_serial_pkg::ADDR_STATUS, 8'he0);
        apb(1'b0, sync_serial_pkg::ADDR_STATUS, 8'h00);
        chk(rv, 32'he0);
        apb(1'b1, sync_serial_pkg::ADDR_STATUS, 8'hc0);
        apb(1'b0, sync_serial_pkg::ADDR_STATUS, 8'h00);
        chk(rv, 32'hc0);
    endtask : t_ext

    // Control write in mid-transfer stops the clock
    task automatic t_abort();
        start(8'h40, 16'h00ff, 16'h0000, 8);
        repeat (700) @(posedge pclk);
        apb(1'b1, sync_serial_pkg::ADDR_CTRL, 8'h40);
        mark = falls;
        chk(32'(mark), 32'h1);
        repeat (1200) @(posedge pclk);
        chk(32'(falls), 32'(mark));
        apb(1'b0, sync_serial_pkg::ADDR_STATUS, 8'h00);
        chk(rv & 32'h1, 32'h0);
        apb(1'b0, sync_serial_pkg::ADDR_IRQ_REQ, 8'h00);
        chk(rv, 32'h0);
    endtask : t_abort

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_level();
        t_taps();
        t_wide();
        t_ext();
        t_abort();
        summarize();
    end

    // Whole run is near 14000 cycles; nearly three times that means a hang
    initial begin
        #400000;
        fail_count++;
        summarize();
    end
endmodule : testbench
